// ---- rtl/cascaded_timer_defs.vh ----
// Function
// - timer mode: 16-bit counter on prescaled clock
// - after start, period match raises irq, clears
// - period compare has no shadow, immediate
// - source clock choices per speed mode
// - event mode counts external falling edges
// - PWM: duty match toggles flip-flop, keeps counting
// - PWM overflow toggles, clears, raises irq
// - init bit presets flip-flop; reset clears it
// - PWM pin is inverse of flip-flop
// - duty staged while running, moved on irq
// - duty read during PWM shows old value
// - stop holds pin; init bit changes later
`ifndef CASCADED_TIMER_DEFS_VH
`define CASCADED_TIMER_DEFS_VH

// register byte addresses
`define OFS_LOWER_CTL     8'h00
`define OFS_UPPER_CTL     8'h04
`define OFS_PERIOD_LOW    8'h08
`define OFS_PERIOD_HIGH   8'h0C
`define OFS_DUTY_LOW      8'h10
`define OFS_DUTY_HIGH     8'h14
`define OFS_CLOCK_CONFIG  8'h18
`define OFS_STATUS        8'h1C
`define OFS_COUNT         8'h20

// lower control fields
`define SRC_SEL_LSB       4
`define SRC_SEL_MSB       6
// upper control fields
`define MODE_LSB          0
`define MODE_MSB          2
`define RUN_BIT           3
`define INIT_BIT          7
// clock config fields
`define DIV_STAGE_BIT     0
`define LOW_SPEED_BIT     1

// reset values
`define CTL_RESET         8'h00
`define CMP_RESET         16'h0000

// modes held in the upper control mode field
`define MODE_TIMER16      3'h4
`define MODE_PWM16        3'h6

// source clock selects
`define SRC_SLOWEST       3'h0
`define SRC_DIV7          3'h1
`define SRC_DIV5          3'h2
`define SRC_DIV3          3'h3
`define SRC_FS            3'h4
`define SRC_DIV1          3'h5
`define SRC_FC            3'h6
`define SRC_EXTERNAL      3'h7

// divider exponents of the prescaler taps
`define EXP_SLOWEST       11
`define EXP_DIV7          7
`define EXP_DIV5          5
`define EXP_DIV3          3
`define EXP_FS_DIV        3
// system clock cycles per low-frequency clock period
`define FS_DIV_DEFAULT    610

`endif

// ---- rtl/falling_edge_sync.v ----
`timescale 1ns/100ps
// two-flop synchroniser with falling-edge pulse
module falling_edge_sync (
   input  wire sys_clk_in,    // system clock
   input  wire reset_in,      // synchronous reset, active high
   input  wire pin_in,        // asynchronous pin level
   output wire fall_out       // one-cycle pulse on falling edge
);
   reg meta_reg;
   reg sync_reg;
   reg last_reg;

   // first flop is read only by the second
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         last_reg <= 1'b1;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // falling edge of the synchronised level
   assign fall_out = last_reg & ~sync_reg;
endmodule // falling_edge_sync

// ---- rtl/source_clock_select.v ----
`timescale 1ns/100ps
`include "cascaded_timer_defs.vh"
// prescaler and source clock multiplexer
module source_clock_select #(
   parameter FS_DIV = `FS_DIV_DEFAULT  // cycles per low-frequency period
) (
   input  wire       sys_clk_in,  // system clock, taken as fc
   input  wire       reset_in,    // synchronous reset, active high
   input  wire [2:0] sel_in,      // source select
   input  wire       div_stage_in, // slowest tap from fs chain
   input  wire       low_speed_in, // low-speed run or idle
   input  wire       ext_fall_in, // external falling edge pulse
   output reg        tick_out     // one-cycle count enable
);
   reg [10:0] pre_reg;
   reg [15:0] fs_cnt_reg;
   reg [2:0]  fs_pre_reg;
   wire       fs_tick;
   wire       fs8_tick;

   // free-running fc prescaler and fs generator
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         pre_reg    <= 11'h000;
         fs_cnt_reg <= 16'h0000;
         fs_pre_reg <= 3'h0;
      end else begin
         pre_reg <= pre_reg + 11'h001;
         if (fs_tick) begin
            fs_cnt_reg <= 16'h0000;
            fs_pre_reg <= fs_pre_reg + 3'h1;
         end else begin
            fs_cnt_reg <= fs_cnt_reg + 16'h0001;
         end
      end
   end

   assign fs_tick  = (fs_cnt_reg == FS_DIV[15:0] - 16'h0001);
   assign fs8_tick = fs_tick & (&fs_pre_reg);

   // low-speed modes allow only fs/8 among internal taps
   always @* begin
      if (sel_in == `SRC_EXTERNAL) begin
         tick_out = ext_fall_in;
      end else if (low_speed_in) begin
         tick_out = (sel_in == `SRC_SLOWEST || sel_in == `SRC_FS) ? fs8_tick : 1'b0;
      end else begin
         case (sel_in)
            `SRC_SLOWEST: tick_out = div_stage_in ? fs8_tick : (&pre_reg[`EXP_SLOWEST-1:0]);
            `SRC_DIV7:    tick_out = &pre_reg[`EXP_DIV7-1:0];
            `SRC_DIV5:    tick_out = &pre_reg[`EXP_DIV5-1:0];
            `SRC_DIV3:    tick_out = &pre_reg[`EXP_DIV3-1:0];
            `SRC_FS:      tick_out = fs_tick;
            `SRC_DIV1:    tick_out = pre_reg[0];
            `SRC_FC:      tick_out = 1'b1;
            default:      tick_out = 1'b0;
         endcase
      end
   end
endmodule // source_clock_select

// ---- rtl/cascaded_timer.v ----
`timescale 1ns/100ps
`include "cascaded_timer_defs.vh"
// cascaded 16-bit timer, event counter and PWM generator
module cascaded_timer #(
   parameter FS_DIV = `FS_DIV_DEFAULT     // cycles per low-frequency period
) (
   input  wire        sys_clk_in,         // system clock, 20 MHz
   input  wire        reset_in,           // synchronous reset, active high
   input  wire        psel_in,            // apb select
   input  wire        penable_in,         // apb enable
   input  wire        pwrite_in,          // apb write
   input  wire [7:0]  paddr_in,           // apb byte address
   input  wire [31:0] pwdata_in,          // apb write data
   output wire        pready_out,         // apb ready
   output reg  [31:0] prdata_out,         // apb read data
   output reg         pslverr_out,        // apb error, unmapped address
   input  wire        external_count_input_in, // external count pin
   output wire        inverted_pwm_pin_out,    // inverted flip-flop pin
   output reg         cascade_match_irq_out    // one-cycle interrupt request
);

   // software-visible registers
   reg  [7:0]  lower_ctl_reg;
   reg  [7:0]  upper_ctl_reg;
   reg  [15:0] period_reg;
   reg  [15:0] duty_stage_reg;
   reg  [15:0] duty_active_reg;
   reg  [1:0]  clock_cfg_reg;

   // engine state
   reg  [15:0] count_reg;
   reg  [15:0] count_next;
   reg         output_flipflop_reg;
   reg         output_flipflop_next;
   reg         irq_next;
   reg  [15:0] duty_active_next;
   reg  [15:0] duty_stage_next;

   wire        ext_fall;
   wire        src_tick;
   wire        running;
   wire        pwm_mode;
   wire        timer_mode;
   wire [2:0]  mode;
   wire [15:0] count_inc;

   // apb decode
   wire        apb_setup;
   wire        apb_write;
   wire        addr_mapped;

   assign mode       = upper_ctl_reg[`MODE_MSB:`MODE_LSB];
   assign running    = upper_ctl_reg[`RUN_BIT];
   assign pwm_mode   = (mode == `MODE_PWM16);
   assign timer_mode = (mode == `MODE_TIMER16);
   assign count_inc  = count_reg + 16'h0001;

   // external pin passes two flops before use
   falling_edge_sync falling_edge_sync_inst (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .pin_in     (external_count_input_in),
      .fall_out   (ext_fall)
   );

   // one tick per count step from the selected source
   source_clock_select #(
      .FS_DIV (FS_DIV)
   ) source_clock_select_inst (
      .sys_clk_in   (sys_clk_in),
      .reset_in     (reset_in),
      .sel_in       (lower_ctl_reg[`SRC_SEL_MSB:`SRC_SEL_LSB]),
      .div_stage_in (clock_cfg_reg[`DIV_STAGE_BIT]),
      .low_speed_in (clock_cfg_reg[`LOW_SPEED_BIT]),
      .ext_fall_in  (ext_fall),
      .tick_out     (src_tick)
   );

   // zero-wait slave: read data is captured in the setup cycle
   assign apb_setup  = psel_in & ~penable_in;
   assign apb_write  = psel_in & penable_in & pwrite_in;
   assign pready_out = 1'b1;

   assign addr_mapped = (paddr_in == `OFS_LOWER_CTL)    || (paddr_in == `OFS_UPPER_CTL)   ||
                        (paddr_in == `OFS_PERIOD_LOW)   || (paddr_in == `OFS_PERIOD_HIGH) ||
                        (paddr_in == `OFS_DUTY_LOW)     || (paddr_in == `OFS_DUTY_HIGH)   ||
                        (paddr_in == `OFS_CLOCK_CONFIG) || (paddr_in == `OFS_STATUS)      ||
                        (paddr_in == `OFS_COUNT);

   // duty readback: during PWM output the value in use until the next irq
   wire [15:0] duty_view;
   assign duty_view = (pwm_mode && running) ? duty_active_reg : duty_stage_reg;

   // read data and error latched in setup, stable through access
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (apb_setup) begin
         pslverr_out <= ~addr_mapped;
         case (paddr_in)
            `OFS_LOWER_CTL:    prdata_out <= {24'h00_0000, lower_ctl_reg};
            `OFS_UPPER_CTL:    prdata_out <= {24'h00_0000, upper_ctl_reg};
            `OFS_PERIOD_LOW:   prdata_out <= {24'h00_0000, period_reg[7:0]};
            `OFS_PERIOD_HIGH:  prdata_out <= {24'h00_0000, period_reg[15:8]};
            `OFS_DUTY_LOW:     prdata_out <= {24'h00_0000, duty_view[7:0]};
            `OFS_DUTY_HIGH:    prdata_out <= {24'h00_0000, duty_view[15:8]};
            `OFS_CLOCK_CONFIG: prdata_out <= {30'h0000_0000, clock_cfg_reg};
            `OFS_STATUS:       prdata_out <= {30'h0000_0000, running, output_flipflop_reg};
            `OFS_COUNT:        prdata_out <= {16'h0000, count_reg};
            default:           prdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // control and compare registers, written at the access edge
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         lower_ctl_reg <= `CTL_RESET;
         upper_ctl_reg <= `CTL_RESET;
         period_reg    <= `CMP_RESET;
         clock_cfg_reg <= 2'b00;
      end else if (apb_write) begin
         case (paddr_in)
            `OFS_LOWER_CTL:    lower_ctl_reg <= pwdata_in[7:0];
            `OFS_UPPER_CTL:    upper_ctl_reg <= pwdata_in[7:0];
            // no shadow stage: match sees the new byte next cycle
            `OFS_PERIOD_LOW:   period_reg[7:0]  <= pwdata_in[7:0];
            `OFS_PERIOD_HIGH:  period_reg[15:8] <= pwdata_in[7:0];
            `OFS_CLOCK_CONFIG: clock_cfg_reg <= pwdata_in[1:0];
            default:           clock_cfg_reg <= clock_cfg_reg;
         endcase
      end
   end

   // duty staging: bytes land in the stage register
   always @* begin
      duty_stage_next = duty_stage_reg;
      if (apb_write && paddr_in == `OFS_DUTY_LOW) begin
         duty_stage_next[7:0] = pwdata_in[7:0];
      end
      if (apb_write && paddr_in == `OFS_DUTY_HIGH) begin
         duty_stage_next[15:8] = pwdata_in[7:0];
      end
   end

   // counting engine
   always @* begin
      count_next           = count_reg;
      output_flipflop_next = output_flipflop_reg;
      irq_next             = 1'b0;
      duty_active_next     = duty_active_reg;

      if (!running) begin
         // stopped: counter cleared, flip-flop held
         count_next = 16'h0000;
         // stopped duty writes move straight to the active register
         duty_active_next = duty_stage_next;
      end else if (src_tick && pwm_mode) begin
         if (count_reg == 16'hFFFF) begin
            // overflow ends the period
            count_next           = 16'h0000;
            output_flipflop_next = ~output_flipflop_reg;
            irq_next             = 1'b1;
            // staged duty taken on the interrupt event
            duty_active_next     = duty_stage_reg;
         end else begin
            // duty match toggles and counting goes on
            count_next = count_inc;
            if (count_inc == duty_active_reg) begin
               output_flipflop_next = ~output_flipflop_reg;
            end
         end
      end else if (src_tick && timer_mode) begin
         // one 16-bit up-counter, internal or external source
         if (count_inc == period_reg) begin
            count_next = 16'h0000;
            irq_next   = 1'b1;
         end else begin
            count_next = count_inc;
         end
      end

      // init bit presets the flip-flop only on writes made while stopped;
      // the stopping write itself leaves the level alone
      if (apb_write && paddr_in == `OFS_UPPER_CTL && !running) begin
         output_flipflop_next = pwdata_in[`INIT_BIT];
      end
   end

   // engine state registers
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         count_reg             <= 16'h0000;
         output_flipflop_reg   <= 1'b0;
         duty_stage_reg        <= `CMP_RESET;
         duty_active_reg       <= `CMP_RESET;
         cascade_match_irq_out <= 1'b0;
      end else begin
         count_reg             <= count_next;
         output_flipflop_reg   <= output_flipflop_next;
         duty_stage_reg        <= duty_stage_next;
         duty_active_reg       <= duty_active_next;
         cascade_match_irq_out <= irq_next;
      end
   end

   // pin shows the inverse of the flip-flop
   assign inverted_pwm_pin_out = ~output_flipflop_reg;

endmodule // cascaded_timer

// ---- test/cascaded_timer_chk.sv ----
`timescale 1ns/100ps
// port-level watch on apb answers, pin and request
module cascaded_timer_chk #(
   parameter FS_DIV = 4                       // fs divide
) (
   input wire        sys_clk_in,              // clock
   input wire        reset_in,                // reset
   input wire        psel_in,                 // select
   input wire        penable_in,              // enable
   input wire        pwrite_in,               // write
   input wire [7:0]  paddr_in,                // address
   input wire [31:0] pwdata_in,               // write data
   input wire        pready_out,              // ready
   input wire [31:0] prdata_out,              // read data
   input wire        pslverr_out,             // error
   input wire        external_count_input_in, // count pin
   input wire        inverted_pwm_pin_out,    // pwm pin
   input wire        cascade_match_irq_out    // request
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   // word-aligned offsets up to the count register
   wire map_ok = (paddr_in[1:0] == 2'b00) && (paddr_in <= 8'h20);
   sequence setup_s; psel_in && !penable_in; endsequence
   sequence access_s; psel_in && penable_in; endsequence
   a_ready_high: assert property (pready_out) else $error("ready low");
   a_err_setup: assert property (setup_s |=> pslverr_out == !$past(map_ok)) else $error("error flag at setup");
   a_err_access: assert property (access_s |-> pslverr_out == !map_ok) else $error("error flag at access");
   a_read_stable: assert property (setup_s ##1 access_s |=> $stable(prdata_out)) else $error("read data moved");
   a_unmapped_zero: assert property (psel_in && penable_in && !map_ok |-> prdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_read_width: assert property (psel_in && penable_in && paddr_in != 8'h20 |-> prdata_out[31:8] == 24'h00_0000)
      else $error("byte register wide");
   a_irq_pulse: assert property (cascade_match_irq_out |=> !cascade_match_irq_out) else $error("long request");
   a_reset_state: assert property ($fell(reset_in) |-> inverted_pwm_pin_out && !cascade_match_irq_out)
      else $error("state after reset");
endmodule // cascaded_timer_chk

// ---- test/event_source.sv ----
`timescale 1ns/100ps
// burst of falling edges on the count pin
module event_source (
   input  wire       sys_clk_in, // clock
   input  wire       go_in,      // start burst
   input  wire [7:0] pulses_in,  // edges wanted
   output reg        pin_out,    // pin, idles high
   output reg        busy_out    // burst running
);
   reg [7:0] left_reg = 8'h00;
   reg [2:0] phase_reg = 3'h0;
   initial pin_out = 1'b1;
   initial busy_out = 1'b0;
   // each level lasts four cycles, above the two-cycle floor
   always @(posedge sys_clk_in) begin
      if (go_in && !busy_out) begin
         left_reg <= pulses_in;
         busy_out <= 1'b1;
         phase_reg <= 3'h0;
      end else if (busy_out) begin
         phase_reg <= phase_reg + 3'h1;
         if (phase_reg == 3'h3) pin_out <= 1'b0;
         if (phase_reg == 3'h7) begin
            pin_out <= 1'b1;
            left_reg <= left_reg - 8'h01;
            busy_out <= (left_reg != 8'h01);
         end
      end
   end
endmodule // event_source

// ---- test/cascaded_timer_bench.sv ----
`timescale 1ns/100ps
`include "cascaded_timer_defs.vh"
module cascaded_timer_bench;
   localparam FS_DIV = 4;
   reg         sys_clk = 1'b0;
   reg         rst = 1'b1;
   reg         psel = 1'b0;
   reg         pen = 1'b0;
   reg         pwr = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0000_0000;
   reg         go = 1'b0;
   reg  [7:0]  npulse = 8'h00;
   wire        pready, perr, pin, irq, ext, ebusy;
   wire [31:0] prdata;
   reg  [31:0] rd;
   reg         rerr;
   reg  [47:0] rows [0:5];
   integer     n_fail = 0, check_count = 0, cycles = 0, irqs = 0, i, t, base;
   always #25 sys_clk = ~sys_clk;
   cascaded_timer #(.FS_DIV(FS_DIV)) cascaded_timer_inst (.sys_clk_in(sys_clk), .reset_in(rst), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
      .prdata_out(prdata), .pslverr_out(perr), .external_count_input_in(ext), .inverted_pwm_pin_out(pin),
      .cascade_match_irq_out(irq));
   event_source event_source_inst (.sys_clk_in(sys_clk), .go_in(go), .pulses_in(npulse), .pin_out(ext),
      .busy_out(ebusy));
   task results;
      begin
         $display("checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task check(input [8*10-1:0] name, input [31:0] exp, input [31:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0s exp %h got %h", name, exp, got);
         end
      end
   endtask
   // one apb transfer; holds everything until ready is seen
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pen <= 1'b0;
         pwr <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         pen <= 1'b1;
         @(posedge sys_clk);
         while (pready !== 1'b1) @(posedge sys_clk);
         rd = prdata;
         rerr = perr;
         psel <= 1'b0;
         pen <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   // edges until the next request, bounded
   task wait_irq(input integer lim, output integer n);
      begin
         n = 0;
         do begin
            @(posedge sys_clk);
            n = n + 1;
         end while (irq !== 1'b1 && n < lim);
      end
   endtask
   // hang guard, well above the pwm period
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 95000) begin
         n_fail = n_fail + 1;
         results;
      end
      if (irq === 1'b1) irqs = irqs + 1;
   end
   // rows: clock config, source, period, expected request spacing
   initial begin
      rows[0] = {8'h00, 8'h06, 16'h0005, 16'h0005};
      rows[1] = {8'h00, 8'h03, 16'h0004, 16'h0020};
      rows[2] = {8'h00, 8'h01, 16'h0002, 16'h0100};
      rows[3] = {8'h00, 8'h00, 16'h0001, 16'h0800};
      rows[4] = {8'h01, 8'h00, 16'h0002, 16'h0040};
      rows[5] = {8'h02, 8'h04, 16'h0003, 16'h0060};
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      check("pin rst", 32'h1, {31'h0, pin});
      for (i = 0; i <= 8'h24; i = i + 4) begin
         apb(1'b0, i[7:0], 32'h0000_0000);
         check("reset rd", 32'h0, rd);
         check("err", {31'h0, i == 8'h24}, {31'h0, rerr});
      end
      for (i = 0; i < 6; i = i + 1) begin
         apb(1'b1, `OFS_UPPER_CTL, 32'h0000_0004);
         apb(1'b1, `OFS_CLOCK_CONFIG, {24'h00_0000, rows[i][47:40]});
         apb(1'b1, `OFS_LOWER_CTL, {25'h0, rows[i][34:32], 4'h0});
         apb(1'b1, `OFS_PERIOD_LOW, {24'h00_0000, rows[i][23:16]});
         apb(1'b1, `OFS_PERIOD_HIGH, {24'h00_0000, rows[i][31:24]});
         apb(1'b1, `OFS_UPPER_CTL, 32'h0000_000C);
         wait_irq(5000, t);
         wait_irq(5000, t);
         check("gap", {16'h0, rows[i][15:0]}, t);
         check("pin", 32'h1, {31'h0, pin});
      end
      apb(1'b1, `OFS_UPPER_CTL, 32'h0000_0004);
      apb(1'b1, `OFS_CLOCK_CONFIG, 32'h0000_0000);
      apb(1'b1, `OFS_LOWER_CTL, 32'h0000_0070);
      apb(1'b1, `OFS_PERIOD_LOW, 32'h0000_0003);
      apb(1'b1, `OFS_UPPER_CTL, 32'h0000_000C);
      base = irqs;
      npulse <= 8'h07;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      for (t = 0; t < 200 && ebusy; t = t + 1) @(posedge sys_clk);
      repeat (6) @(posedge sys_clk);
      check("events", 32'h2, irqs - base);
      // pwm on fc, duty 0x10, then 0x20 staged while running
      apb(1'b1, `OFS_UPPER_CTL, 32'h0000_0006);
      apb(1'b1, `OFS_LOWER_CTL, 32'h0000_0060);
      apb(1'b1, `OFS_DUTY_LOW, 32'h0000_0010);
      apb(1'b1, `OFS_DUTY_HIGH, 32'h0000_0000);
      apb(1'b1, `OFS_UPPER_CTL, 32'h0000_000E); // pin taken as enabled at top level
      apb(1'b1, `OFS_DUTY_LOW, 32'h0000_0020);
      apb(1'b1, `OFS_DUTY_HIGH, 32'h0000_0000);
      apb(1'b0, `OFS_DUTY_LOW, 32'h0000_0000);
      check("duty old", 32'h10, rd);
      wait_irq(70000, t);
      check("pin ovf", 32'h1, {31'h0, pin});
      t = 0;
      do begin
         @(posedge sys_clk);
         t = t + 1;
      end while (pin !== 1'b0 && t < 100);
      check("match", 32'h20, t);
      apb(1'b0, `OFS_DUTY_LOW, 32'h0000_0000);
      check("duty new", 32'h20, rd);
      apb(1'b1, `OFS_UPPER_CTL, 32'h0000_0006);
      check("pin stop", 32'h0, {31'h0, pin});
      apb(1'b1, `OFS_UPPER_CTL, 32'h0000_0006);
      check("pin init0", 32'h1, {31'h0, pin});
      apb(1'b1, `OFS_UPPER_CTL, 32'h0000_0086);
      check("pin init1", 32'h0, {31'h0, pin});
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      check("pin rst2", 32'h1, {31'h0, pin});
      results;
   end
endmodule // cascaded_timer_bench
bind cascaded_timer cascaded_timer_chk #(.FS_DIV(FS_DIV)) cascaded_timer_chk_inst (.sys_clk_in(sys_clk_in),
   .reset_in(reset_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
   .external_count_input_in(external_count_input_in), .inverted_pwm_pin_out(inverted_pwm_pin_out),
   .cascade_match_irq_out(cascade_match_irq_out));
